// *** opc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module opc_host (
    input wire logic frame,
    output logic scl,
    output logic sda_oe_n
);
    initial begin
        scl = 1'h1;
        sda_oe_n = 1'h1;
    end
    // clock stands high between frames, 200 ns a bit
    always @(posedge frame) begin
        for (int i = 0; i < 4; i++) begin
            scl = 1'h0;
            #50 sda_oe_n = i[0];
            #50 scl = 1'h1;
            #100;
        end
        sda_oe_n = 1'h1;
    end
endmodule
`default_nettype wire

// *** opc_pin_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - laser disabled when disable pin high or soft disable bit set
// - transmit-off status mirrors the disable pin level
// - irq enable bit 4 resets 0; 0 analog sense, 1 open-drain output
// - enabled shared pin carries the internal interrupt, active low, open-drain
// - receive rate output is pin OR soft bit
// - receive rate pin status mirrors that pin
// - setup C bit 7 picks general output or pulsed active-low reset
// - setup F bit 2 picks loss-of-signal (0) or transmit rate (1)
// - setup F bit 3: 0 low when normal, 1 high when normal
// - loss asserted while power below threshold, released when above
// - loss status reads the real pin level, wired-OR included, inverted when setup F bit 3 is set
// - transmit rate output is soft bit OR pin
// - setup C bit 4: 0 open-drain rate output, 1 general output
// - serial data only pulled low or released by either side
// - transmit rate pin status mirrors that pin
module opc_pin_ctrl import opc_pkg::*; #(
    parameter int PWR_W = 10,
    parameter int RST_UNIT_CYC = OPC_RST_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    // pins
    input wire logic tx_off_pin,
    input wire logic rx_rate_sel_pin,
    input wire logic tx_rate_sel_pin,
    input wire logic los_pin_in,
    output logic los_pin_oe_n,
    output logic los_pin_out,
    output logic rx_rate_pin_oe_n,
    output logic rx_rate_pin_out,
    output logic qpin_oe_n,
    output logic qpin_out,
    output logic irq_pin_oe_n,
    output logic irq_pin_out,
    output logic supply_sense_en,
    input wire logic serial_clk_pin,
    input wire logic serial_data_in,
    output logic serial_data_oe_n,
    output logic serial_data_out,
    output logic serial_clk_seen,
    // serial engine side
    input wire logic serial_data_pull,
    // internal control
    input wire logic soft_tx_off,
    input wire logic soft_rx_rate_sel,
    input wire logic soft_tx_rate_sel,
    input wire logic [7:0] user_control_reg,
    input wire logic [7:0] vendor_setup_c,
    input wire logic [7:0] vendor_setup_f,
    input wire logic irq_internal,
    input wire logic [PWR_W-1:0] rx_power_sense,
    input wire logic [PWR_W-1:0] lost_signal_threshold,
    input wire logic pulse_reset_start,
    input wire logic [OPC_RST_CODE_W-1:0] pulse_reset_code,
    // outputs and status
    output logic tx_disable,
    output logic tx_off_status,
    output logic rx_rate_pin_status,
    output logic tx_rate_pin_status,
    output logic signal_lost_status,
    output logic serial_data_level,
    output logic pulse_reset_busy
);
    localparam int NSYNC = 6;
    localparam int CNT_W = 24;
    localparam int WARM_W = 2;

    // synchronised pad levels
    logic [NSYNC-1:0] pins_s;
    logic tx_off_s, rx_rate_s, tx_rate_s, los_s, sclk_s, sda_s;
    // serial clock edge detector and synchroniser fill
    logic sclk_prev_q, sclk_prev_d;
    logic [WARM_W-1:0] warm_cnt_q, warm_cnt_d;
    logic sync_warm;
    // received-power comparator
    logic lost_q, lost_d;
    // pulsed reset width; wide enough for the longest code at a slow unit
    logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    logic [CNT_W-1:0] rst_load;
    // laser disable
    logic tx_disable_q, tx_disable_d;
    // pin sources ahead of the open-drain stage
    logic rx_rate_out, tx_rate_out, general_out, rx_signal_lost_out;
    logic los_drive_lvl;

    // pad inputs, serial pair included, pass two flops before any logic
    opc_sync #(.WIDTH(NSYNC)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({serial_data_in, serial_clk_pin, los_pin_in,
                   tx_rate_sel_pin, rx_rate_sel_pin, tx_off_pin}),
        .sync_out(pins_s)
    );
    assign {sda_s, sclk_s, los_s, tx_rate_s, rx_rate_s, tx_off_s} = pins_s;

    // laser disable is registered so the driver never sees a decode glitch
    always_comb begin
        tx_disable_d = tx_off_s | soft_tx_off;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_disable_q <= OPC_TX_OFF_RST;
        end else begin
            tx_disable_q <= tx_disable_d;
        end
    end

    // synchroniser outputs hold reset zeros for two edges after release
    always_comb begin
        warm_cnt_d = warm_cnt_q;
        if (!sync_warm) begin
            warm_cnt_d = warm_cnt_q + WARM_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            warm_cnt_q <= '0;
        end else begin
            warm_cnt_q <= warm_cnt_d;
        end
    end

    assign sync_warm = warm_cnt_q == WARM_W'(OPC_SYNC_STAGES);

    // previous level forced to idle high until the synchroniser is full,
    // else reset zeros followed by an idle bus read as a false rising edge
    always_comb begin
        sclk_prev_d = sclk_s | ~sync_warm;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_q <= OPC_SCL_IDLE;
        end else begin
            sclk_prev_q <= sclk_prev_d;
        end
    end

    // no hysteresis: the equal case keeps the previous state
    always_comb begin
        lost_d = lost_q;
        if (rx_power_sense < lost_signal_threshold) begin
            lost_d = 1'b1;
        end else if (rx_power_sense > lost_signal_threshold) begin
            lost_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lost_q <= OPC_LOST_RST;
        end else begin
            lost_q <= lost_d;
        end
    end

    // code 0 still gives one unit so the pulse is never lost;
    // a restart during a pulse reloads the full width
    always_comb begin
        rst_load = CNT_W'(RST_UNIT_CYC) * (CNT_W'(pulse_reset_code) + CNT_W'(1));
        rst_cnt_d = rst_cnt_q;
        if (pulse_reset_start) begin
            rst_cnt_d = rst_load;
        end else if (rst_cnt_q != '0) begin
            rst_cnt_d = rst_cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_q <= '0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
        end
    end

    assign tx_disable = tx_disable_q;
    // status bits are the synchronised pads, two edges behind the pins
    assign tx_off_status = tx_off_s;
    assign rx_rate_pin_status = rx_rate_s;
    assign tx_rate_pin_status = tx_rate_s;
    assign signal_lost_status = los_s ^ vendor_setup_f[OPC_F_LOS_POL_BIT];
    assign serial_data_level = sda_s;
    assign serial_clk_seen = sclk_s & ~sclk_prev_q;
    assign pulse_reset_busy = rst_cnt_q != '0;

    assign rx_rate_out = rx_rate_s | soft_rx_rate_sel;
    assign tx_rate_out = soft_tx_rate_sel | tx_rate_s;
    assign general_out = vendor_setup_c[OPC_C_GEN_OUT_LVL_BIT];
    assign rx_signal_lost_out = lost_q;

    // loss polarity: bit 0 means low when normal, i.e. high when lost
    always_comb begin
        if (vendor_setup_f[OPC_F_TX_RATE_SEL_BIT]) begin
            los_drive_lvl = tx_rate_out;
        end else begin
            los_drive_lvl = rx_signal_lost_out ^ vendor_setup_f[OPC_F_LOS_POL_BIT];
        end
    end

    // open-drain: drive low only, release for high
    assign los_pin_out = 1'b0;
    assign los_pin_oe_n = los_drive_lvl;
    assign rx_rate_pin_out = 1'b0;
    assign rx_rate_pin_oe_n = vendor_setup_c[OPC_C_GEN_OUT_SEL_BIT] ?
                              general_out : rx_rate_out;
    assign qpin_out = 1'b0;
    assign qpin_oe_n = vendor_setup_c[OPC_C_QPIN_FUNC_BIT] ?
                       ~pulse_reset_busy : vendor_setup_c[OPC_C_QPIN_LVL_BIT];
    assign supply_sense_en = ~user_control_reg[OPC_UC_IRQ_EN_BIT];
    assign irq_pin_out = 1'b0;
    assign irq_pin_oe_n = ~(user_control_reg[OPC_UC_IRQ_EN_BIT] & irq_internal);
    assign serial_data_out = 1'b0;
    assign serial_data_oe_n = ~serial_data_pull;
endmodule
`default_nettype wire

// *** opc_pin_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module opc_pin_ctrl_properties import opc_pkg::*; (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic tx_off_pin,
    input wire logic rx_rate_sel_pin,
    input wire logic tx_rate_sel_pin,
    input wire logic serial_clk_pin,
    input wire logic soft_tx_off,
    input wire logic soft_rx_rate_sel,
    input wire logic soft_tx_rate_sel,
    input wire logic irq_internal,
    input wire logic pulse_reset_start,
    input wire logic serial_data_pull,
    input wire logic tx_disable,
    input wire logic tx_off_status,
    input wire logic rx_rate_pin_status,
    input wire logic tx_rate_pin_status,
    input wire logic los_pin_oe_n,
    input wire logic rx_rate_pin_oe_n,
    input wire logic qpin_oe_n,
    input wire logic irq_pin_oe_n,
    input wire logic supply_sense_en,
    input wire logic serial_data_oe_n,
    input wire logic serial_clk_seen,
    input wire logic pulse_reset_busy,
    input wire logic [7:0] user_control_reg,
    input wire logic [7:0] vendor_setup_c,
    input wire logic [7:0] vendor_setup_f
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    soft_off_a: assert property (soft_tx_off |=> tx_disable)
        else $error("soft off left laser on");
    off_status_a: assert property (tx_off_status == $past(tx_off_pin, 2))
        else $error("off status lags wrongly");
    rx_status_a: assert property (rx_rate_pin_status == $past(rx_rate_sel_pin, 2))
        else $error("rx rate status wrong");
    tx_status_a: assert property (tx_rate_pin_status == $past(tx_rate_sel_pin, 2))
        else $error("tx rate status wrong");
    rx_or_a: assert property (!vendor_setup_c[OPC_C_GEN_OUT_SEL_BIT] |->
        rx_rate_pin_oe_n == (soft_rx_rate_sel | $past(rx_rate_sel_pin, 2)))
        else $error("rx rate out wrong");
    tx_or_a: assert property (vendor_setup_f[OPC_F_TX_RATE_SEL_BIT] |->
        los_pin_oe_n == (soft_tx_rate_sel | $past(tx_rate_sel_pin, 2)))
        else $error("tx rate out wrong");
    irq_pin_a: assert property (
        (irq_pin_oe_n == !(user_control_reg[OPC_UC_IRQ_EN_BIT] & irq_internal))
        && (supply_sense_en == !user_control_reg[OPC_UC_IRQ_EN_BIT]))
        else $error("irq pin wrong");
    pulse_go_a: assert property (
        vendor_setup_c[OPC_C_QPIN_FUNC_BIT] && pulse_reset_start
        |=> pulse_reset_busy && !qpin_oe_n) else $error("reset pulse missing");
    clk_edge_a: assert property (serial_clk_seen |->
        $past(serial_clk_pin, 2) && !$past(serial_clk_pin, 3))
        else $error("false serial clock edge");
    data_od_a: assert property (serial_data_oe_n == !serial_data_pull)
        else $error("data line pull wrong");
endmodule
bind opc_pin_ctrl opc_pin_ctrl_properties u_opc_pin_ctrl_properties (.*);
`default_nettype wire

// *** opc_pkg.sv ***
`default_nettype none
package opc_pkg;
    // vendor setup byte C fields
    localparam int OPC_C_QPIN_FUNC_BIT = 7;
    localparam int OPC_C_GEN_OUT_SEL_BIT = 4;
    localparam int OPC_C_GEN_OUT_LVL_BIT = 0;
    localparam int OPC_C_QPIN_LVL_BIT = 1;
    // vendor setup byte F fields
    localparam int OPC_F_TX_RATE_SEL_BIT = 2;
    localparam int OPC_F_LOS_POL_BIT = 3;
    // user control register field
    localparam int OPC_UC_IRQ_EN_BIT = 4;
    localparam logic [7:0] OPC_USER_CTRL_RST = 8'h00;
    localparam logic [7:0] OPC_SETUP_RST = 8'h00;
    // pulsed reset width code (bits 0 to 2 of the reset control byte)
    localparam int OPC_RST_CODE_W = 3;
    localparam int OPC_CLK_HZ = 40000000;
    localparam int OPC_RST_UNIT_US = 10;
    localparam int OPC_RST_UNIT_CYC = OPC_CLK_HZ / 1000000 * OPC_RST_UNIT_US;
    localparam int OPC_SYNC_STAGES = 2;
    // reset levels: laser off, signal counted lost, serial clock idle high
    localparam logic OPC_TX_OFF_RST = 1'b1;
    localparam logic OPC_LOST_RST = 1'b1;
    localparam logic OPC_SCL_IDLE = 1'b1;
endpackage
`default_nettype wire

// *** opc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module opc_sync import opc_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, resetn, tx_off_pin, rx_rate_sel_pin, tx_rate_sel_pin, soft_tx_off, frame;
    logic soft_rx_rate_sel, soft_tx_rate_sel, irq_internal, pulse_reset_start, serial_data_pull;
    logic los_pin_oe_n, los_pin_out, rx_rate_pin_oe_n, rx_rate_pin_out, qpin_oe_n, qpin_out;
    logic irq_pin_oe_n, irq_pin_out, supply_sense_en, serial_data_oe_n, serial_data_out;
    logic serial_clk_seen, tx_disable, tx_off_status, rx_rate_pin_status, tx_rate_pin_status;
    logic signal_lost_status, serial_data_level, pulse_reset_busy, los_ext_n, host_oe_n;
    logic serial_clk_pin;
    logic [7:0] user_control_reg, vendor_setup_c, vendor_setup_f;
    logic [9:0] rx_power_sense, lost_signal_threshold;
    logic [2:0] pulse_reset_code;
    int bad_count, check_count, n;
    // open-drain wires: any party pulling wins, pull-up otherwise
    wire los_pin_in = los_pin_oe_n & los_ext_n;
    wire serial_data_in = serial_data_oe_n & host_oe_n;
    opc_pin_ctrl #(.RST_UNIT_CYC(2)) u_opc_pin_ctrl (.*);
    opc_host u_opc_host (.frame(frame), .scl(serial_clk_pin), .sda_oe_n(host_oe_n));
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_tx;
        tx_off_pin = 1'h1;
        step(3);
        chk("tx pin", 8'h03, {tx_disable, tx_off_status});
        {tx_off_pin, soft_tx_off} = 2'h1;
        step(3);
        chk("tx soft", 8'h02, {tx_disable, tx_off_status});
        soft_tx_off = 1'h0;
        step(3);
        chk("tx idle", 8'h00, {tx_disable, tx_off_status});
        $display("t_tx done");
    endtask
    task automatic t_rate;
        vendor_setup_f = 8'h04;
        for (int i = 0; i < 4; i++) begin
            {rx_rate_sel_pin, soft_rx_rate_sel} = i[1:0];
            {tx_rate_sel_pin, soft_tx_rate_sel} = ~i[1:0];
            step(3);
            chk("rx rate", i != 0, rx_rate_pin_oe_n);
            chk("tx rate", i != 3, los_pin_oe_n);
            chk("pin status", {i[1], !i[1]}, {rx_rate_pin_status, tx_rate_pin_status});
        end
        $display("t_rate done");
    endtask
    task automatic t_los;
        {vendor_setup_f, rx_power_sense} = {8'h00, 10'h050};
        step(4);
        chk("loss low", 8'h03, {los_pin_oe_n, signal_lost_status});
        rx_power_sense = 10'h200;
        step(4);
        chk("loss clear", 8'h00, {los_pin_oe_n, signal_lost_status});
        vendor_setup_f = 8'h08;
        step(4);
        chk("loss pol", 8'h02, {los_pin_oe_n, signal_lost_status});
        los_ext_n = 1'h0;
        step(4);
        chk("loss wired", 8'h01, signal_lost_status);
        los_ext_n = 1'h1;
        $display("t_los done");
    endtask
    task automatic t_irq;
        irq_internal = 1'h1;
        step(1);
        chk("irq off", 8'h03, {supply_sense_en, irq_pin_oe_n});
        user_control_reg = 8'h10;
        step(1);
        chk("irq on", 8'h00, {supply_sense_en, irq_pin_oe_n});
        $display("t_irq done");
    endtask
    task automatic t_pulse;
        {vendor_setup_c, pulse_reset_code, pulse_reset_start} = {8'h80, 3'h1, 1'h1};
        step(1);
        pulse_reset_start = 1'h0;
        n = 0;
        while (pulse_reset_busy === 1'h1 && n < 50) begin
            chk("qpin low", 8'h00, qpin_oe_n);
            n++;
            step(1);
        end
        chk("pulse width", 8'h04, n[7:0]);
        if (n == 50) final_report();
        vendor_setup_c = 8'h12;
        step(1);
        chk("gen outs", 8'h02, {qpin_oe_n, rx_rate_pin_oe_n});
        $display("t_pulse done");
    endtask
    task automatic t_serial;
        n = 0;
        frame = 1'h1;
        serial_data_pull = 1'h0;
        repeat (60) begin
            step(1);
            if (serial_clk_seen === 1'h1) n++;
        end
        chk("clk edges", 8'h04, n[7:0]);
        chk("data idle", 8'h01, serial_data_level);
        serial_data_pull = 1'h1;
        step(1);
        chk("data pull", 8'h00, serial_data_oe_n);
        step(2);
        chk("data level", 8'h00, serial_data_level);
        chk("od lows", 8'h00, {los_pin_out, rx_rate_pin_out, qpin_out, irq_pin_out, serial_data_out});
        $display("t_serial done");
    endtask
    initial begin
        {resetn, tx_off_pin, rx_rate_sel_pin, tx_rate_sel_pin, soft_tx_off, frame} = '0;
        {soft_rx_rate_sel, soft_tx_rate_sel, irq_internal, pulse_reset_start} = '0;
        {serial_data_pull, user_control_reg, vendor_setup_c, vendor_setup_f} = '0;
        {rx_power_sense, lost_signal_threshold, pulse_reset_code} = {10'h000, 10'h100, 3'h0};
        los_ext_n = 1'h1;
        step(8);
        resetn = 1'h1;
        step(2);
        t_tx();
        t_rate();
        t_los();
        t_irq();
        t_pulse();
        t_serial();
        final_report();
    end
endmodule
`default_nettype wire
